// >>> dv/dac_double_buffered_input_latch_tb_top.sv
`timescale 1ns/1ns
// Bench for the host controller driving the converter latch model
module dac_double_buffered_input_latch_tb_top;
   localparam int DLY = 1;
   localparam int WD_NS = 5000 * ddl_pkg::CLK_PERIOD_NS;

   logic core_clk;
   logic rst_b;
   logic req_valid;
   logic req_ready;
   logic [15:0] req_word;
   logic [1:0] req_mode;
   logic req_high_first;
   logic req_cs_strobe;
   logic done;
   logic [15:0] dac_data;
   logic dac_cs_n;
   logic upper_byte_load_n;
   logic lower_byte_load_n;
   logic output_register_load_n;
   logic [7:0] upper_q;
   logic [7:0] lower_q;
   logic [15:0] conv_q;
   int num_errors;
   int checks;

   ddl_host_ctrl i_dut (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req_word(req_word),
      .req_mode(req_mode),
      .req_high_first(req_high_first),
      .req_cs_strobe(req_cs_strobe),
      .done(done),
      .dac_data(dac_data),
      .dac_cs_n(dac_cs_n),
      .upper_byte_load_n(upper_byte_load_n),
      .lower_byte_load_n(lower_byte_load_n),
      .output_register_load_n(output_register_load_n)
   );

   ddl_dac_model i_dac (
      .data(dac_data),
      .cs_n(dac_cs_n),
      .upper_byte_load_n(upper_byte_load_n),
      .lower_byte_load_n(lower_byte_load_n),
      .output_register_load_n(output_register_load_n),
      .upper_q(upper_q),
      .lower_q(lower_q),
      .conv_q(conv_q)
   );

   // ----------------------------------------------------------------
   // Clock, compare and closing
   // ----------------------------------------------------------------
   // Free running system clock
   always #(ddl_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   // One compare, counted
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------
   // One request; poke raises a second request while busy, which must be ignored
   // Entered just after a clock edge, leaves just after one
   task automatic do_write(input logic [15:0] w, input logic [1:0] m, input logic hf,
                           input logic cs, input logic poke);
      logic [15:0] old;
      logic bad;
      int n;
      old = conv_q;
      bad = 1'b0;
      n = 0;
      req_word = w;
      req_mode = m;
      req_high_first = hf;
      req_cs_strobe = cs;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #DLY;
         n++;
      end
      @(posedge core_clk);
      #DLY;
      req_valid = 1'b0;
      n = 0;
      // Converter may only ever show the old word or the finished one
      while (done !== 1'b1 && n < 100) begin
         if (conv_q !== old && conv_q !== w) begin
            bad = 1'b1;
         end
         req_valid = poke && (n == 3);
         if (poke && n == 3) begin
            req_word = ~w;
         end
         @(posedge core_clk);
         #DLY;
         n++;
      end
      req_valid = 1'b0;
      chk(16'(n >= 100), 16'h0000);
      chk(16'(bad), 16'h0000);
      chk({upper_q, lower_q}, w);
      chk(conv_q, w);
      repeat (3) @(posedge core_clk);
      #DLY;
      chk(16'({dac_cs_n, upper_byte_load_n, lower_byte_load_n}), 16'h0007);
      chk(16'(done), 16'h0000);
      chk(conv_q, w);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Every mode, byte order and strobe style, words differing each time
   task automatic test_modes;
      logic [15:0] w;
      for (int i = 0; i < 16; i++) begin
         w = 16'h5A3C ^ (16'h1111 * 16'(i));
         do_write(w, 2'(i >> 2), i[0], i[1], 1'b0);
      end
      $display("test_modes finished");
   endtask

   // A request while busy must not start a second write
   task automatic test_refused;
      do_write(16'hE71B, ddl_pkg::MODE_SYNC8, 1'b1, 1'b0, 1'b1);
      repeat (10) @(posedge core_clk);
      #DLY;
      chk(16'(dac_cs_n), 16'h0001);
      chk(conv_q, 16'hE71B);
      chk(dac_data, 16'h1B1B);
      $display("test_refused finished");
   endtask

   // Reset in mid-write parks every pin, then a fresh write still works
   task automatic test_reset;
      req_word = 16'h0F0F;
      req_mode = ddl_pkg::MODE_THIRD8;
      req_valid = 1'b1;
      repeat (6) @(posedge core_clk);
      #DLY;
      req_valid = 1'b0;
      rst_b = 1'b0;
      #5;
      chk(16'({dac_cs_n, upper_byte_load_n, lower_byte_load_n, output_register_load_n}),
          16'h000F);
      chk(16'(req_ready), 16'h0000);
      repeat (3) @(posedge core_clk);
      #DLY;
      rst_b = 1'b1;
      @(posedge core_clk);
      #DLY;
      chk(16'(req_ready), 16'h0000);
      do_write(16'hC3A5, ddl_pkg::MODE_THIRD8, 1'b0, 1'b1, 1'b0);
      // Load-only step leaves the second byte standing on both halves
      chk(dac_data, 16'hC3C3);
      $display("test_reset finished");
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   // Reset held three cycles, inputs moved just after rising edges
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_word = 16'h0000;
      req_mode = 2'h0;
      req_high_first = 1'b0;
      req_cs_strobe = 1'b0;
      num_errors = 0;
      checks = 0;
      repeat (3) @(posedge core_clk);
      #DLY;
      rst_b = 1'b1;
      test_modes();
      test_refused();
      test_reset();
      conclude();
   end

   // Roughly ten times the expected run length
   initial begin
      #(WD_NS);
      num_errors++;
      $display("[ERR] t=%0t watchdog expired", $time);
      conclude();
   end
endmodule // dac_double_buffered_input_latch_tb_top

// >>> dv/ddl_dac_model.sv
`timescale 1ns/1ns
// Converter latch stage on the far side of the host pins; it has no clock of its own
module ddl_dac_model (
   input wire logic [15:0] data, // Data pins from the host
   input wire logic cs_n, // Device select, active low
   input wire logic upper_byte_load_n, // Upper first rank enable, active low
   input wire logic lower_byte_load_n, // Lower first rank enable, active low
   input wire logic output_register_load_n, // Converter register load, active low
   output logic [7:0] upper_q, // Upper half of the first rank
   output logic [7:0] lower_q, // Lower half of the first rank
   output logic [15:0] conv_q // Converter register, the converted word
);
   // ----------------------------------------------------------------
   // First rank
   // ----------------------------------------------------------------
   // upper half follows data
   always_latch begin
      if (!cs_n && !upper_byte_load_n) begin
         upper_q <= data[15:8];
      end
   end

   always_latch begin
      if (!cs_n && !lower_byte_load_n) begin
         lower_q <= data[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Converter register
   // ----------------------------------------------------------------
   // cascade through first rank
   // Chained latches let data pass straight through when all four controls are low
   always_latch begin
      if (!cs_n && !output_register_load_n) begin
         conv_q <= {upper_q, lower_q};
      end
   end
endmodule // ddl_dac_model

// >>> rtl/ddl_host_ctrl.sv
`timescale 1ns/1ns
module ddl_host_ctrl (
   input logic core_clk, // 10 MHz system clock
   input logic rst_b, // Asynchronous reset, active low
   input logic req_valid, // Write request present
   output logic req_ready, // Ready to take a request
   input logic [15:0] req_word, // Word to convert
   input logic [1:0] req_mode, // Word, two-byte sync or three-cycle load
   input logic req_high_first, // Byte modes: upper byte first
   input logic req_cs_strobe, // Strobe with select, addresses on enables
   output logic done, // One-cycle pulse when the write ends
   output logic [15:0] dac_data, // Data pins to the converter
   output logic dac_cs_n, // Device select, active low
   output logic upper_byte_load_n, // Upper first rank enable, active low
   output logic lower_byte_load_n, // Lower first rank enable, active low
   output logic output_register_load_n // Converter register load, active low
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_n_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Step decoding
   // ----------------------------------------------------------------
   // Which control lines a step drives; bytes picked by address
   // at most one byte enable per step in byte modes, both in word mode
   function automatic logic [2:0] step_sel(logic [1:0] mode, logic [1:0] step, logic hf);
      logic [2:0] first_b;
      logic [2:0] second_b;
      first_b = hf ? ddl_pkg::SEL_UPPER : ddl_pkg::SEL_LOWER;
      second_b = hf ? ddl_pkg::SEL_LOWER : ddl_pkg::SEL_UPPER;
      case (mode)
         ddl_pkg::MODE_SYNC8: begin
            step_sel = (step == ddl_pkg::STEP_FIRST) ? first_b : (second_b | ddl_pkg::SEL_LOAD);
         end
         ddl_pkg::MODE_THIRD8: begin
            if (step == ddl_pkg::STEP_FIRST) begin
               step_sel = first_b;
            end else if (step == ddl_pkg::STEP_SECOND) begin
               step_sel = second_b;
            end else begin
               step_sel = ddl_pkg::SEL_LOAD;
            end
         end
         default: begin
            step_sel = ddl_pkg::SEL_UPPER | ddl_pkg::SEL_LOWER;
         end
      endcase
   endfunction

   function automatic logic [1:0] step_last(logic [1:0] mode);
      case (mode)
         ddl_pkg::MODE_SYNC8: step_last = ddl_pkg::STEP_SECOND;
         ddl_pkg::MODE_THIRD8: step_last = ddl_pkg::STEP_THIRD;
         default: step_last = ddl_pkg::STEP_FIRST;
      endcase
   endfunction

   // A byte host drives its byte on both halves; a load-only step keeps data
   function automatic logic [15:0] step_data(logic [1:0] mode, logic [1:0] step, logic hf,
                                             logic [15:0] word, logic [15:0] prev);
      logic [2:0] sel;
      logic [7:0] b;
      sel = step_sel(mode, step, hf);
      b = (sel & ddl_pkg::SEL_UPPER) != '0 ? word[ddl_pkg::DATA_W-1:ddl_pkg::BYTE_W]
                                           : word[ddl_pkg::BYTE_W-1:0];
      if (sel == ddl_pkg::SEL_LOAD) begin
         step_data = prev;
      end else if ((mode != ddl_pkg::MODE_SYNC8) && (mode != ddl_pkg::MODE_THIRD8)) begin
         step_data = word;
      end else begin
         step_data = {b, b};
      end
   endfunction

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   ddl_pkg::ddl_state_t state_reg;
   logic [1:0] step_reg;
   logic [1:0] mode_reg;
   logic hf_reg;
   logic cs_style_reg;
   logic [15:0] word_reg;
   logic start_reg;
   logic [ddl_pkg::CNT_W-1:0] cycles_reg;
   logic req_ready_reg;
   logic done_reg;
   logic ld_hold_reg;
   logic [15:0] data_reg;
   logic cs_n_reg;
   logic ub_n_reg;
   logic lb_n_reg;
   logic ld_n_reg;
   logic [2:0] cur_sel;
   logic accept;
   logic advance;
   logic is8;

   ddl_tmr_if tmr_bus ();

   ddl_strobe_timer u_timer (
      .clk(core_clk),
      .rst_n(rst_sync_n_reg),
      .tif(tmr_bus)
   );

   assign tmr_bus.start = start_reg;
   assign tmr_bus.cycles = cycles_reg;
   assign cur_sel = step_sel(mode_reg, step_reg, hf_reg);
   assign accept = (state_reg == ddl_pkg::ST_IDLE) && req_valid && req_ready_reg;
   assign advance = (state_reg == ddl_pkg::ST_HOLD) && tmr_bus.done
                    && (step_reg != step_last(mode_reg));
   assign is8 = (mode_reg == ddl_pkg::MODE_SYNC8) || (mode_reg == ddl_pkg::MODE_THIRD8);

   // Phase walk: setup, strobe, hold for each step
   always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         state_reg <= ddl_pkg::ST_IDLE;
         step_reg <= ddl_pkg::STEP_FIRST;
         start_reg <= 1'b0;
         cycles_reg <= '0;
         req_ready_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         case (state_reg)
            ddl_pkg::ST_IDLE: begin
               req_ready_reg <= !accept;
               if (accept) begin
                  state_reg <= ddl_pkg::ST_SETUP;
                  step_reg <= ddl_pkg::STEP_FIRST;
                  start_reg <= 1'b1;
                  cycles_reg <= ddl_pkg::SETUP_CYC;
               end
            end
            ddl_pkg::ST_SETUP: begin
               if (tmr_bus.done) begin
                  state_reg <= ddl_pkg::ST_STROBE;
                  start_reg <= 1'b1;
                  if (cs_style_reg) begin
                     cycles_reg <= ddl_pkg::CS_PULSE_CYC;
                  end else if ((cur_sel & ddl_pkg::SEL_LOAD) != '0) begin
                     cycles_reg <= ddl_pkg::OUTPUT_REGISTER_LOAD_N_PULSE_CYC;
                  end else begin
                     cycles_reg <= ddl_pkg::BYTE_PULSE_CYC;
                  end
               end
            end
            ddl_pkg::ST_STROBE: begin
               if (tmr_bus.done) begin
                  state_reg <= ddl_pkg::ST_HOLD;
                  start_reg <= 1'b1;
                  cycles_reg <= ddl_pkg::HOLD_CYC;
               end
            end
            default: begin
               if (advance) begin
                  state_reg <= ddl_pkg::ST_SETUP;
                  step_reg <= 2'(step_reg + ddl_pkg::STEP_ONE);
                  start_reg <= 1'b1;
                  cycles_reg <= ddl_pkg::SETUP_CYC;
               end else if (tmr_bus.done) begin
                  state_reg <= ddl_pkg::ST_IDLE;
                  req_ready_reg <= 1'b1;
                  done_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // Request capture; word mode keeps the converter register open
   always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         mode_reg <= ddl_pkg::MODE_WORD16;
         hf_reg <= 1'b0;
         cs_style_reg <= 1'b0;
         word_reg <= '0;
         ld_hold_reg <= 1'b0;
      end else if (accept) begin
         mode_reg <= req_mode;
         hf_reg <= req_high_first;
         cs_style_reg <= req_cs_strobe;
         word_reg <= req_word;
         // load held low for word host
         ld_hold_reg <= (req_mode != ddl_pkg::MODE_SYNC8) && (req_mode != ddl_pkg::MODE_THIRD8);
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         data_reg <= '0;
      end else if (accept) begin
         data_reg <= step_data(req_mode, ddl_pkg::STEP_FIRST, req_high_first, req_word, data_reg);
      end else if (advance) begin
         data_reg <= step_data(mode_reg, 2'(step_reg + ddl_pkg::STEP_ONE), hf_reg, word_reg,
                               data_reg);
      end
   end

   // ----------------------------------------------------------------
   // Pin drive, one cycle behind the sequencer
   // ----------------------------------------------------------------
   // Pins lag data by a cycle, so data is settled before any strobe falls
   always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         cs_n_reg <= 1'b1;
         ub_n_reg <= 1'b1;
         lb_n_reg <= 1'b1;
         ld_n_reg <= 1'b1;
      end else if (state_reg == ddl_pkg::ST_IDLE) begin
         cs_n_reg <= 1'b1;
         ub_n_reg <= 1'b1;
         lb_n_reg <= 1'b1;
         ld_n_reg <= !ld_hold_reg;
      end else if (cs_style_reg) begin
         cs_n_reg <= state_reg != ddl_pkg::ST_STROBE;
         ub_n_reg <= (cur_sel & ddl_pkg::SEL_UPPER) == '0;
         lb_n_reg <= (cur_sel & ddl_pkg::SEL_LOWER) == '0;
         ld_n_reg <= ((cur_sel & ddl_pkg::SEL_LOAD) == '0) && !ld_hold_reg;
      end else begin
         cs_n_reg <= 1'b0;
         ub_n_reg <= !((state_reg == ddl_pkg::ST_STROBE) && ((cur_sel & ddl_pkg::SEL_UPPER) != '0));
         lb_n_reg <= !((state_reg == ddl_pkg::ST_STROBE) && ((cur_sel & ddl_pkg::SEL_LOWER) != '0));
         ld_n_reg <= !(((state_reg == ddl_pkg::ST_STROBE) && ((cur_sel & ddl_pkg::SEL_LOAD) != '0))
                       || ld_hold_reg);
      end
   end

   assign req_ready = req_ready_reg;
   assign done = done_reg;
   assign dac_data = data_reg;
   assign dac_cs_n = cs_n_reg;
   assign upper_byte_load_n = ub_n_reg;
   assign lower_byte_load_n = lb_n_reg;
   assign output_register_load_n = ld_n_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_n_reg);

   property p_data_between_strobes;
      !$stable(data_reg) |-> cs_n_reg || (ub_n_reg && lb_n_reg);
   endproperty
   a_data_between_strobes: assert property (p_data_between_strobes)
      else $error("data changed while a byte latch was open");

   property p_select_under_enable;
      (!cs_style_reg && (!ub_n_reg || !lb_n_reg)) |-> !cs_n_reg;
   endproperty
   a_select_under_enable: assert property (p_select_under_enable)
      else $error("byte enable strobed without device select");

   property p_word_both_enables;
      ((mode_reg == ddl_pkg::MODE_WORD16) && $fell(ub_n_reg)) |-> $fell(lb_n_reg) && !ld_n_reg;
   endproperty
   a_word_both_enables: assert property (p_word_both_enables)
      else $error("word write did not strobe both enables together");

   property p_sync_load_second;
      ((mode_reg == ddl_pkg::MODE_SYNC8) && $fell(ld_n_reg))
         |-> ($fell(ub_n_reg) || $fell(lb_n_reg)) && !$past(done_reg);
   endproperty
   a_sync_load_second: assert property (p_sync_load_second)
      else $error("sync load did not ride on the second byte enable");

   property p_third_load_alone;
      ((mode_reg == ddl_pkg::MODE_THIRD8) && !ld_n_reg) |-> ub_n_reg && lb_n_reg;
   endproperty
   a_third_load_alone: assert property (p_third_load_alone)
      else $error("third cycle load overlapped a byte enable");

   property p_one_byte_at_a_time;
      is8 |-> ub_n_reg || lb_n_reg;
   endproperty
   a_one_byte_at_a_time: assert property (p_one_byte_at_a_time)
      else $error("byte host opened both halves at once");

   property p_select_strobes_address;
      (cs_style_reg && $fell(cs_n_reg)) |-> !$past(ub_n_reg) || !$past(lb_n_reg)
                                            || !$past(ld_n_reg);
   endproperty
   a_select_strobes_address: assert property (p_select_strobes_address)
      else $error("select strobed before an address line was set");

   sequence s_enable_pulse_held;
      // Timer reloads a cycle late, so every phase spans three pin cycles
      (!cs_n_reg && !ub_n_reg) [*3] ##1 (!cs_n_reg && ub_n_reg);
   endsequence

   property p_gated_enable_pulse;
      (!cs_style_reg && $fell(ub_n_reg)) |-> s_enable_pulse_held;
   endproperty
   a_gated_enable_pulse: assert property (p_gated_enable_pulse)
      else $error("gated enable pulse short or select dropped");

endmodule // ddl_host_ctrl

// >>> rtl/ddl_pkg.sv
package ddl_pkg;

   // ----------------------------------------------------------------
   // Clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_SETUP_NS = 60;
   localparam int T_HOLD_NS = 20;
   localparam int T_BYTE_PULSE_NS = 60;
   localparam int T_OUTPUT_REGISTER_LOAD_N_PULSE_NS = 70;
   localparam int T_CS_PULSE_NS = 70;

   // Least times round up, never below one cycle
   function automatic int ns_to_cycles(int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return c;
   endfunction

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns_to_cycles(T_SETUP_NS));
   localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(ns_to_cycles(T_HOLD_NS));
   localparam logic [CNT_W-1:0] BYTE_PULSE_CYC = CNT_W'(ns_to_cycles(T_BYTE_PULSE_NS));
   localparam logic [CNT_W-1:0] OUTPUT_REGISTER_LOAD_N_PULSE_CYC = CNT_W'(ns_to_cycles(T_OUTPUT_REGISTER_LOAD_N_PULSE_NS));
   localparam logic [CNT_W-1:0] CS_PULSE_CYC = CNT_W'(ns_to_cycles(T_CS_PULSE_NS));

   // ----------------------------------------------------------------
   // Data layout, modes, strobe selection
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;

   localparam logic [1:0] MODE_WORD16 = 2'h0;
   localparam logic [1:0] MODE_SYNC8 = 2'h1;
   localparam logic [1:0] MODE_THIRD8 = 2'h2;

   localparam logic [1:0] STEP_FIRST = 2'h0;
   localparam logic [1:0] STEP_SECOND = 2'h1;
   localparam logic [1:0] STEP_THIRD = 2'h2;
   localparam logic [1:0] STEP_ONE = 2'h1;

   localparam logic [2:0] SEL_UPPER = 3'h4;
   localparam logic [2:0] SEL_LOWER = 3'h2;
   localparam logic [2:0] SEL_LOAD = 3'h1;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} ddl_state_t;

endpackage

// >>> rtl/ddl_strobe_timer.sv
`timescale 1ns/1ns
module ddl_strobe_timer (
   input logic clk, // System clock
   input logic rst_n, // Synchronised reset, active low
   ddl_tmr_if.tmr tif // Phase start and done
);

   logic [ddl_pkg::CNT_W-1:0] count_reg;
   logic done_reg;

   // ----------------------------------------------------------------
   // Down counter, done pulses as the last cycle expires
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (tif.start) begin
         count_reg <= tif.cycles;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - ddl_pkg::CNT_ONE;
      end
   end

   // A fresh start cancels a pending done so phases never overlap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= !tif.start && (count_reg == ddl_pkg::CNT_ONE);
      end
   end

   assign tif.done = done_reg;

endmodule // ddl_strobe_timer

// >>> rtl/ddl_tmr_if.sv
`timescale 1ns/1ns
// Start and finish of one timed phase
interface ddl_tmr_if;
   logic start;
   logic [ddl_pkg::CNT_W-1:0] cycles;
   logic done;
   modport ctl (output start, output cycles, input done);
   modport tmr (input start, input cycles, output done);
endinterface
